/* File: logic/unb_uart9.sv */
// nine-bit serial port with address recognition behind an axi4-lite slave
// Behaviour
// - nine-bit frame: start, eight, ninth, stop
// - ninth bit from tx flag, into rx flag
// - fixed mode rate clock/64, or /32 doubled
// - buffer write requests; start at rollover
// - start, then data, shift inserts zeros
// - final shift, done flag at rollover eleven, ten in mode 1
// - falling edge resets counter, presets ones
// - majority of samples seven, eight, nine
// - nonzero start bit abandons the frame
// - load only if done clear, filter passes
// - eight bits to buffer; stop irrelevant except to the mode 1 filter
// - variable mode: timer overflow over 32, or 16 doubled
// - timer rate: clock/12/(256-reload) or faster
// - reception needs enable and falling edge
// - missing stop sets error; shared top bit
// - filter ignored mode 0; mode 1 stop
// - nine-bit filter: ninth set, address hit
// - eight-bit filter: stop valid, address hit
// - given address compares only masked bits
// - broadcast is address or mask
// - reset clears address and mask
`timescale 1ns/1ps
module unb_uart9
    import unb_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              wvalid,
    output logic                   wready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    output logic                   bvalid,
    input  wire logic              bready,
    output logic [1:0]             bresp,
    input  wire logic              arvalid,
    output logic                   arready,
    input  wire logic [ADDR_W-1:0] araddr,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    input  wire logic              rxd,
    output logic                   txd
);

    // ****************************************************
    // helpers
    // ****************************************************

    // one reload timer step: overflow flag above next count
    function automatic logic [8:0] tmr_step(input logic [7:0] c,
                                            input logic [7:0] rl);
        if (c == TMR_TOP) begin
            return {1'b1, rl};
        end
        return {1'b0, c + 8'h01};
    endfunction

    function automatic logic maj3(input logic a,
                                  input logic b,
                                  input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    // given or broadcast hit; zero mask matches all
    function automatic logic addr_hit(input logic [7:0] d,
                                      input logic [7:0] sa,
                                      input logic [7:0] se);
        logic [7:0] bc;
        bc = sa | se;
        return (((d ^ sa) & se) == 8'h00) |
               (((d ^ bc) & bc) == 8'h00);
    endfunction

    unb_state_t s_reg;
    unb_state_t s_next;
    logic [1:0] mode;
    logic [8:0] t1_step;
    logic [8:0] brt_step;
    logic       pre_hit;
    logic       ovf;
    logic       tick;
    logic       roll;
    logic       fall;
    logic       bitv;
    logic [3:0] rxc_n;
    logic [3:0] rx_end;
    logic [7:0] rx_d;
    logic       rx_b9;
    logic       rx_load;
    logic       ti_set;
    logic       fe_set;
    logic [7:0] ctl_rd;
    logic [7:0] wd;

    // ****************************************************
    // next-state logic
    // ****************************************************

    // whole port in one pass: line, timing, engines, bus
    always_comb begin
        s_next  = s_reg;
        mode    = {s_reg.mode_hi, s_reg.mode_lo};
        bitv    = 1'b0;
        rxc_n   = s_reg.rxc + 4'h1;
        rx_d    = s_reg.rx_shift[7:0];
        rx_b9   = s_reg.rx_shift[8];
        rx_load = 1'b0;
        ti_set  = 1'b0;
        fe_set  = 1'b0;
        wd      = s_reg.w_data;
        rx_end  = (mode == MODE_8VAR) ? RX_END_8BIT : RX_END_9BIT;

        // receive pin: second stage feeds the samples; it and a third stage give the falling edge
        s_next.rxd_s1  = rxd;
        s_next.rxd_s2  = s_reg.rxd_s1;
        s_next.rxd_prv = s_reg.rxd_s2;
        fall = s_reg.rxd_prv & ~s_reg.rxd_s2;

        pre_hit  = (s_reg.pre == PRE_LAST);
        s_next.pre = pre_hit ? 4'h0 : s_reg.pre + 4'h1;
        t1_step  = tmr_step(s_reg.t1_cnt, s_reg.t1_rl);
        brt_step = tmr_step(s_reg.brt_cnt, s_reg.brt_rl);
        if (s_reg.timer1_speedup | pre_hit) begin
            s_next.t1_cnt = t1_step[7:0];
        end
        if (s_reg.baud_timer_speedup | pre_hit) begin
            s_next.brt_cnt = brt_step[7:0];
        end
        ovf = s_reg.brs ? brt_step[8] & (s_reg.baud_timer_speedup | pre_hit)
                        : t1_step[8] & (s_reg.timer1_speedup | pre_hit);

        // oversample tick: every overflow doubled, else half
        if (ovf) begin
            s_next.ovf_half = ~s_reg.ovf_half;
        end
        s_next.fix_cnt = s_reg.fix_cnt + 2'h1;
        // fixed mode: tick every 4 clocks, or every 2
        if (mode == MODE_9FIX) begin
            tick = s_reg.baud_double ? s_reg.fix_cnt[0]
                              : (s_reg.fix_cnt == FIX_LAST);
        end else begin
            tick = ovf & (s_reg.baud_double | s_reg.ovf_half);
        end

        // ************************************************
        // transmitter, paced by its own divide-by-16
        // ************************************************
        if (tick) begin
            s_next.txc = s_reg.txc + 4'h1;
        end
        roll = tick & (s_reg.txc == OVS_LAST);
        if (roll) begin
            case (s_reg.tx_st)
                TX_IDLE: begin
                    if (s_reg.tx_req && mode != MODE_SHIFT) begin
                        s_next.tx_req   = 1'b0;
                        s_next.tx_st    = TX_SEND;
                        s_next.tx_rolls = 4'h1;
                        s_next.txd      = 1'b0;
                    end
                end
                TX_SEND: begin
                    s_next.tx_rolls = s_reg.tx_rolls + 4'h1;
                    // data enabled one bit after start
                    if (s_reg.tx_rolls == 4'h1) begin
                        s_next.txd = s_reg.tx_shift[0];
                    // last shift ends send, sets done
                    end else if (s_next.tx_rolls ==
                                 ((mode == MODE_8VAR) ? TX_END_8BIT
                                                      : TX_END_9BIT)) begin
                        s_next.tx_shift = {1'b0, s_reg.tx_shift[9:1]};
                        s_next.txd      = LINE_IDLE;
                        s_next.tx_st    = TX_IDLE;
                        ti_set          = 1'b1;
                    end else begin
                        // zeros come in from the left
                        s_next.tx_shift = {1'b0, s_reg.tx_shift[9:1]};
                        s_next.txd      = s_reg.tx_shift[1];
                    end
                end
                default: s_next.tx_st = TX_IDLE;
            endcase
        end

        // ************************************************
        // receiver
        // ************************************************
        case (s_reg.rx_st)
            RX_HUNT: begin
                // enable plus falling edge starts a frame
                if (s_reg.ren && mode != MODE_SHIFT && fall) begin
                    s_next.rx_st    = RX_FRAME;
                    s_next.rxc      = 4'h0;
                    s_next.rx_idx   = 4'h0;
                    s_next.rx_shift = RX_PRESET;
                end
            end
            RX_FRAME: begin
                if (tick) begin
                    s_next.rxc = rxc_n;
                    // samples at states 7, 8 and 9
                    if (rxc_n == SMP_FIRST || rxc_n == SMP_MID) begin
                        s_next.smp = {s_reg.smp[0], s_reg.rxd_s2};
                    end
                    if (rxc_n == SMP_LAST) begin
                        bitv = maj3(s_reg.smp[1], s_reg.smp[0],
                                    s_reg.rxd_s2);
                        if (s_reg.rx_idx == 4'h0) begin
                            if (bitv) begin
                                s_next.rx_st = RX_HUNT;
                            end else begin
                                s_next.rx_idx = 4'h1;
                            end
                        end else if (s_reg.rx_idx != rx_end) begin
                            // data and ninth bit, lsb first
                            s_next.rx_shift = {bitv, s_reg.rx_shift[8:1]};
                            s_next.rx_idx   = s_reg.rx_idx + 4'h1;
                        end else begin
                            s_next.rx_st = RX_HUNT;
                            // low stop bit is a frame error
                            fe_set = ~bitv;
                            if (mode == MODE_8VAR) begin
                                rx_d  = s_reg.rx_shift[8:1];
                                rx_b9 = bitv;
                            end
                            // gate on done flag and filter
                            rx_load = ~s_reg.ri &
                                      (~s_reg.mpe |
                                       (rx_b9 &
                                        addr_hit(rx_d, s_reg.slave_address,
                                                 s_reg.slave_address_mask)));
                        end
                    end
                end
            end
            default: s_next.rx_st = RX_HUNT;
        endcase

        // ************************************************
        // axi4-lite slave
        // ************************************************

        // address and data are latched independently
        if (awvalid && !s_reg.aw_hold) begin
            s_next.aw_hold = 1'b1;
            s_next.aw_addr = awaddr;
        end
        if (wvalid && !s_reg.w_hold) begin
            s_next.w_hold = 1'b1;
            s_next.w_data = wdata[7:0];
            s_next.w_en   = wstrb[0];
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end

        // write takes effect once both halves are held
        if (s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid) begin
            s_next.aw_hold = 1'b0;
            s_next.w_hold  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = RESP_OKAY;
            case (s_reg.aw_addr)
                OFF_SER_CTL: begin
                    if (s_reg.w_en) begin
                        // a zero top bit clears the error when selected
                        if (s_reg.frame_err_select) begin
                            s_next.fe = s_reg.fe & wd[CTL_MODE_HI];
                        end else begin
                            s_next.mode_hi = wd[CTL_MODE_HI];
                        end
                        s_next.mode_lo = wd[CTL_MODE_LO];
                        s_next.mpe     = wd[CTL_MP_EN];
                        s_next.ren     = wd[CTL_RX_EN];
                        s_next.tb8     = wd[CTL_TX_B9];
                        s_next.rb8     = wd[CTL_RX_B9];
                        s_next.ti      = wd[CTL_TX_DONE];
                        s_next.ri      = wd[CTL_RX_DONE];
                    end
                end
                OFF_SER_BUF: begin
                    // ninth bit copied from the tx flag
                    if (s_reg.w_en) begin
                        s_next.tx_req   = 1'b1;
                        s_next.tx_shift = (mode == MODE_8VAR)
                                        ? {2'h3, wd}
                                        : {1'b1, s_reg.tb8, wd};
                    end
                end
                OFF_PWR_CTL: begin
                    if (s_reg.w_en) begin
                        s_next.baud_double  = wd[PWR_DOUBLE];
                        s_next.frame_err_select = wd[PWR_FE_SEL];
                    end
                end
                OFF_AUX_CTL: begin
                    if (s_reg.w_en) begin
                        s_next.timer1_speedup  = wd[AUX_T1_SPD];
                        s_next.baud_timer_speedup = wd[AUX_BRT_SPD];
                        s_next.brs    = wd[AUX_SRC_SEL];
                    end
                end
                OFF_T1_RELOAD: begin
                    if (s_reg.w_en) begin
                        s_next.t1_rl = wd;
                    end
                end
                OFF_BRT_RELOAD: begin
                    if (s_reg.w_en) begin
                        s_next.brt_rl = wd;
                    end
                end
                OFF_SLV_ADDR: begin
                    if (s_reg.w_en) begin
                        s_next.slave_address = wd;
                    end
                end
                OFF_SLV_MASK: begin
                    if (s_reg.w_en) begin
                        s_next.slave_address_mask = wd;
                    end
                end
                default: s_next.bresp = RESP_SLVERR;
            endcase
        end

        // control read shows error or mode bit
        ctl_rd = {s_reg.frame_err_select ? s_reg.fe : s_reg.mode_hi,
                  s_reg.mode_lo, s_reg.mpe, s_reg.ren, s_reg.tb8,
                  s_reg.rb8, s_reg.ti, s_reg.ri};

        // read answer is registered, one cycle after the address
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (arvalid && !s_reg.rvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = RESP_OKAY;
            case (araddr)
                OFF_SER_CTL:    s_next.rdata = ctl_rd;
                OFF_SER_BUF:    s_next.rdata = s_reg.rx_buf;
                OFF_PWR_CTL:    s_next.rdata = {s_reg.baud_double, s_reg.frame_err_select,
                                                6'h00};
                OFF_AUX_CTL:    s_next.rdata = {1'b0, s_reg.timer1_speedup, 3'h0,
                                                s_reg.baud_timer_speedup, 1'b0,
                                                s_reg.brs};
                OFF_T1_RELOAD:  s_next.rdata = s_reg.t1_rl;
                OFF_BRT_RELOAD: s_next.rdata = s_reg.brt_rl;
                OFF_SLV_ADDR:   s_next.rdata = s_reg.slave_address;
                OFF_SLV_MASK:   s_next.rdata = s_reg.slave_address_mask;
                default: begin
                    s_next.rdata = REG_RST;
                    s_next.rresp = RESP_SLVERR;
                end
            endcase
        end

        // hardware sets come last so they beat a same-cycle clear
        if (ti_set) begin
            s_next.ti = 1'b1;
        end
        if (fe_set) begin
            s_next.fe = 1'b1;
        end
        // eight data bits to buffer, ninth to flag
        if (rx_load) begin
            s_next.rx_buf = rx_d;
            s_next.rb8    = rx_b9;
            s_next.ri     = 1'b1;
        end
    end

    // ****************************************************
    // state register
    // ****************************************************

    // reset zeroes address and mask with the rest; txd and the rxd stages load idle high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg         <= '0;
            s_reg.txd     <= LINE_IDLE;
            s_reg.rxd_s1  <= LINE_IDLE;
            s_reg.rxd_s2  <= LINE_IDLE;
            s_reg.rxd_prv <= LINE_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // handshake outputs from held flags; data from flip-flops
    assign awready = ~s_reg.aw_hold;
    assign wready  = ~s_reg.w_hold;
    assign bvalid  = s_reg.bvalid;
    assign bresp   = s_reg.bresp;
    assign arready = ~s_reg.rvalid;
    assign rvalid  = s_reg.rvalid;
    assign rdata   = {24'h000000, s_reg.rdata};
    assign rresp   = s_reg.rresp;
    assign txd     = s_reg.txd;

endmodule

/* File: logic/unb_pkg.sv */
// constants, register map and state layout of the nine-bit serial port
package unb_pkg;

    // ****************************************************
    // register map (byte addresses, one word each)
    // ****************************************************
    localparam int         ADDR_W         = 8;
    localparam logic [7:0] OFF_SER_CTL    = 8'h00;
    localparam logic [7:0] OFF_SER_BUF    = 8'h04;
    localparam logic [7:0] OFF_PWR_CTL    = 8'h08;
    localparam logic [7:0] OFF_AUX_CTL    = 8'h0C;
    localparam logic [7:0] OFF_T1_RELOAD  = 8'h10;
    localparam logic [7:0] OFF_BRT_RELOAD = 8'h14;
    localparam logic [7:0] OFF_SLV_ADDR   = 8'h18;
    localparam logic [7:0] OFF_SLV_MASK   = 8'h1C;

    // ****************************************************
    // field positions
    // ****************************************************
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_MP_EN   = 5;
    localparam int CTL_RX_EN   = 4;
    localparam int CTL_TX_B9   = 3;
    localparam int CTL_RX_B9   = 2;
    localparam int CTL_TX_DONE = 1;
    localparam int CTL_RX_DONE = 0;
    localparam int PWR_DOUBLE  = 7;
    localparam int PWR_FE_SEL  = 6;
    localparam int AUX_T1_SPD  = 6;
    localparam int AUX_BRT_SPD = 2;
    localparam int AUX_SRC_SEL = 0;

    // ****************************************************
    // reset values, codes and cycle counts
    // ****************************************************
    localparam logic [7:0] REG_RST     = 8'h00;
    localparam logic       LINE_IDLE   = 1'h1;
    localparam logic [1:0] MODE_SHIFT  = 2'h0;
    localparam logic [1:0] MODE_8VAR   = 2'h1;
    localparam logic [1:0] MODE_9FIX   = 2'h2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] PRE_LAST    = 4'hB;
    localparam logic [7:0] TMR_TOP     = 8'hFF;
    localparam logic [1:0] FIX_LAST    = 2'h3;
    localparam logic [3:0] OVS_LAST    = 4'hF;
    localparam logic [3:0] SMP_FIRST   = 4'h7;
    localparam logic [3:0] SMP_MID     = 4'h8;
    localparam logic [3:0] SMP_LAST    = 4'h9;
    localparam logic [3:0] TX_END_8BIT = 4'hA;
    localparam logic [3:0] TX_END_9BIT = 4'hB;
    localparam logic [3:0] RX_END_8BIT = 4'h9;
    localparam logic [3:0] RX_END_9BIT = 4'hA;
    localparam logic [8:0] RX_PRESET   = 9'h1FF;

    typedef enum logic {TX_IDLE, TX_SEND} unb_tx_st_t;
    typedef enum logic {RX_HUNT, RX_FRAME} unb_rx_st_t;

    // whole state of the port
    typedef struct packed {
        logic             rxd_s1;
        logic             rxd_s2;
        logic             rxd_prv;
        logic [3:0]       pre;
        logic [7:0]       t1_cnt;
        logic [7:0]       brt_cnt;
        logic             ovf_half;
        logic [1:0]       fix_cnt;
        logic [3:0]       txc;
        unb_tx_st_t       tx_st;
        logic             tx_req;
        logic [3:0]       tx_rolls;
        logic [9:0]       tx_shift;
        logic             txd;
        unb_rx_st_t       rx_st;
        logic [3:0]       rxc;
        logic [3:0]       rx_idx;
        logic [1:0]       smp;
        logic [8:0]       rx_shift;
        logic             mode_hi;
        logic             mode_lo;
        logic             mpe;
        logic             ren;
        logic             tb8;
        logic             rb8;
        logic             ti;
        logic             ri;
        logic             fe;
        logic [7:0]       rx_buf;
        logic             baud_double;
        logic             frame_err_select;
        logic             timer1_speedup;
        logic             baud_timer_speedup;
        logic             brs;
        logic [7:0]       t1_rl;
        logic [7:0]       brt_rl;
        logic [7:0]       slave_address;
        logic [7:0]       slave_address_mask;
        logic             aw_hold;
        logic [7:0]       aw_addr;
        logic             w_hold;
        logic [7:0]       w_data;
        logic             w_en;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [7:0]       rdata;
        logic [1:0]       rresp;
    } unb_state_t;

endpackage

/* File: tb/unb_uart9_assertions.sv */
// concurrent checks on the ports of the nine-bit serial port
`timescale 1ns/1ps
module unb_uart9_assertions
    import unb_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic        txd
);
    // ****************************************************
    // bus answers and line timing
    // ****************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wtaken; awvalid && awready && wvalid && wready; endsequence
    sequence s_low; !txd [*8]; endsequence
    property p_wresp; s_wtaken |-> ##2 bvalid; endproperty
    property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    property p_arblk; rvalid |-> !arready; endproperty
    property p_rans; arvalid && arready |=> rvalid; endproperty
    property p_rhi; rvalid |-> rdata[31:8] == 24'h000000; endproperty
    property p_awblk; awvalid && awready |=> !awready; endproperty
    // shortest legal bit is sixteen clocks, so a start bit never glitches
    property p_start; $fell(txd) |-> s_low; endproperty
    a_wresp: assert property (p_wresp) else $error("write answer late");
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    a_arblk: assert property (p_arblk) else $error("read taken while busy");
    a_rans: assert property (p_rans) else $error("read answer late");
    a_rhi: assert property (p_rhi) else $error("upper read bits set");
    a_awblk: assert property (p_awblk) else $error("address not held");
    a_start: assert property (p_start) else $error("short low bit");
endmodule
bind unb_uart9 unb_uart9_assertions chk_u (.aclk, .aresetn, .awvalid,
    .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid,
    .arready, .rvalid, .rready, .rdata, .txd);

/* File: tb/unb_far_node.sv */
// remote serial node: frames onto rxd, samples frames from txd
`timescale 1ns/1ps
module unb_far_node (
    input wire logic aclk,
    output logic     rxd,
    input wire logic txd
);
    // ****************************************************
    // frame tasks
    // ****************************************************
    // line is driven high from the start, so idle reads high
    initial rxd = 1'h1;
    // start, data, ninth marks address, stop
    task send(input logic [7:0] d, input logic n, s, input int per);
        logic [10:0] f;
        f = {s, n, d, 1'h0};
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (per) @(posedge aclk);
        end
        rxd <= 1'h1;
    endtask
    // mid-bit sampling keeps clear of the launch edges
    task recv(output logic [10:0] f, input int per);
        @(negedge txd);
        repeat (per / 2) @(posedge aclk);
        for (int i = 0; i < 11; i++) begin
            f[i] = txd;
            repeat (per) @(posedge aclk);
        end
    endtask
endmodule

/* File: tb/unb_uart9_bench.sv */
// self-checking bench of the nine-bit serial port
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module unb_uart9_bench
    import unb_pkg::*;
;
    logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
    logic        bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, rxd, txd;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000, rdata, v;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, r;
    logic [10:0] f;
    int          mismatches = 0, n_checks = 0, cyc = 0;
    // ****************************************************
    // harness, bus tasks and scenarios
    // ****************************************************
    always #2 aclk = ~aclk;
    unb_uart9 dut_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .rxd, .txd);
    unb_far_node far_u (.aclk, .rxd, .txd);
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // late ready on the answer holds the slave in its stand phase
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic pa, pw, ha, hw;
        pa = 1'h1;
        pw = 1'h1;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (pa || pw) begin
            @(negedge aclk);
            ha = pa && awready;
            hw = pw && wready;
            @(posedge aclk);
            awvalid <= pa && !ha;
            wvalid <= pw && !hw;
            pa = pa && !ha;
            pw = pw && !hw;
        end
        do @(negedge aclk); while (bvalid !== 1'h1);
        @(posedge aclk);
        bready <= 1'h1;
        @(posedge aclk);
        bready <= 1'h0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
        araddr <= a;
        arvalid <= 1'h1;
        do @(negedge aclk); while (arready !== 1'h1);
        @(posedge aclk);
        arvalid <= 1'h0;
        do @(negedge aclk); while (rvalid !== 1'h1);
        @(posedge aclk);
        rready <= 1'h1;
        // answer taken as it stands at the handshake edge
        @(negedge aclk);
        d = rdata;
        e = rresp;
        @(posedge aclk);
        rready <= 1'h0;
    endtask
    task t_reg;
        rd(OFF_SLV_ADDR, v, r);
        `CHK(v, 32'h00000000)
        rd(OFF_SLV_MASK, v, r);
        `CHK(v, 32'h00000000)
        rd(8'h40, v, r);
        `CHK(r, RESP_SLVERR)
    endtask
    // fixed mode, undoubled: 64 clocks a bit, ninth bit from control
    task t_tx;
        int i;
        wr(OFF_SER_CTL, 8'h88);
        fork
            far_u.recv(f, 64);
            wr(OFF_SER_BUF, 8'hA5);
        join
        `CHK(f, {2'h3, 8'hA5, 1'h0})
        i = 0;
        do begin rd(OFF_SER_CTL, v, r); i++; end while (v[1] !== 1'h1 && i < 40);
        `CHK(v, 32'h0000008A)
    endtask
    // variable mode off timer one at full speed: two clocks a tick
    task t_m3;
        wr(OFF_AUX_CTL, 8'h40);
        wr(OFF_T1_RELOAD, 8'hFE);
        wr(OFF_SER_CTL, 8'h48);
        fork
            far_u.recv(f, 32);
            wr(OFF_SER_BUF, 8'h3C);
        join
        `CHK(f, {2'h3, 8'h3C, 1'h0})
        rd(OFF_SER_CTL, v, r);
        `CHK(v, 32'h0000004A)
    endtask
    // doubled rate, filter on, mask leaves bit one free
    task t_rx;
        wr(OFF_SER_CTL, 8'hB0);
        wr(OFF_PWR_CTL, 8'hC0);
        wr(OFF_SLV_ADDR, 8'hC0);
        wr(OFF_SLV_MASK, 8'hFD);
        far_u.send(8'hC2, 1'h0, 1'h1, 32);
        rd(OFF_SER_CTL, v, r);
        `CHK(v, 32'h00000030)
        far_u.send(8'hC2, 1'h1, 1'h1, 32);
        rd(OFF_SER_CTL, v, r);
        `CHK(v, 32'h00000035)
        rd(OFF_SER_BUF, v, r);
        `CHK(v, 32'h000000C2)
        far_u.send(8'hFF, 1'h1, 1'h0, 32);
        rd(OFF_SER_CTL, v, r);
        `CHK(v, 32'h000000B5)
        rd(OFF_SER_BUF, v, r);
        `CHK(v, 32'h000000C2)
    endtask
    // main sequence after sixteen reset cycles
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reg();
        t_tx();
        t_rx();
        t_m3();
        complete_run();
    end
    // hang guard, well above the few thousand cycles needed
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            complete_run();
        end
    end
endmodule
